// ===== logic/pad_port.v
// Port A 24-pin data register pair with AXI4-Lite register access
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pad_map.vh"

module pad_port #(
  parameter PINS = `PAD_PINS
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [3:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [3:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  input  wire [PINS-1:0]  pin_in,
  output wire [PINS-1:0]  pin_out,
  output wire [PINS-1:0]  pin_oe
);
  // Byte lanes follow the strobe bits; pin counts off a lane edge are not supported
  localparam            LANE       = `PAD_LANE_BITS;
  localparam            LANES      = PINS / LANE;
  localparam [PINS-1:0] DIR_RESET  = `PAD_DIR_RESET;
  localparam [PINS-1:0] FUNC_RESET = `PAD_FUNC_RESET;

  reg  [3:0]      awaddr_q;
  reg  [3:0]      awaddr_d;
  reg             aw_have_q;
  reg             aw_have_d;
  reg  [31:0]     wdata_q;
  reg  [31:0]     wdata_d;
  reg  [3:0]      wstrb_q;
  reg  [3:0]      wstrb_d;
  reg             w_have_q;
  reg             w_have_d;
  reg             bvalid_d;
  reg             rvalid_d;
  reg  [31:0]     rdata_d;
  reg  [PINS-1:0] dir_q;
  wire [PINS-1:0] dir_d;
  reg  [PINS-1:0] func_q;
  wire [PINS-1:0] func_d;
  wire [PINS-1:0] rd_bits;
  wire [PINS-1:0] wr_en;
  wire [PINS-1:0] wr_val;
  wire            do_write;
  wire            wr_low;
  wire            wr_high;
  wire            wr_dir;
  wire            wr_func;
  reg  [31:0]     rd_word;

  // Hold address and data apart so either may arrive first
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_low        = do_write && (awaddr_q == `PAD_OFF_LOW_DATA);
  assign wr_high       = do_write && (awaddr_q == `PAD_OFF_HIGH_DATA);
  assign wr_dir        = do_write && (awaddr_q == `PAD_OFF_DIRECTION);
  assign wr_func       = do_write && (awaddr_q == `PAD_OFF_FUNCTION);

  // Next state of the write channel; the response waits for both halves
  always @* begin
    aw_have_d = aw_have_q;
    awaddr_d  = awaddr_q;
    w_have_d  = w_have_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'h1;
      awaddr_d  = s_axi_awaddr & `PAD_WORD_MASK;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'h1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_have_d = 1'h0;
      w_have_d  = 1'h0;
      bvalid_d  = 1'h1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'h0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'h0;
      w_have_q     <= 1'h0;
      awaddr_q     <= `PAD_OFF_LOW_DATA;
      wdata_q      <= `PAD_WORD_ZERO;
      wstrb_q      <= `PAD_STRB_NONE;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= `PAD_RESP_OKAY;
    end else begin
      aw_have_q    <= aw_have_d;
      w_have_q     <= w_have_d;
      awaddr_q     <= awaddr_d;
      wdata_q      <= wdata_d;
      wstrb_q      <= wstrb_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp  <= `PAD_RESP_OKAY;
    end
  end

  // Direction and function-select registers, one byte lane per strobe bit
  genvar b;
  generate
    for (b = 0; b < LANES; b = b + 1) begin : g_lane
      assign dir_d[b*LANE +: LANE]  = (wr_dir && wstrb_q[b]) ?
                                      wdata_q[b*LANE +: LANE] : dir_q[b*LANE +: LANE];
      assign func_d[b*LANE +: LANE] = (wr_func && wstrb_q[b]) ?
                                      wdata_q[b*LANE +: LANE] : func_q[b*LANE +: LANE];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      dir_q  <= DIR_RESET;
      func_q <= FUNC_RESET;
    end else begin
      dir_q  <= dir_d;
      func_q <= func_d;
    end
  end

  // Low register feeds pins 15..0, high register bits 7..0 feed 23..16
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_pin
      if (i < `PAD_LOW_BITS) begin : g_lo
        assign wr_en[i]  = wr_low && wstrb_q[i/LANE];
        assign wr_val[i] = wdata_q[i];
      end else begin : g_hi
        assign wr_en[i]  = wr_high && wstrb_q[(i-`PAD_LOW_BITS)/LANE];
        assign wr_val[i] = wdata_q[i-`PAD_LOW_BITS];
      end
      pad_pin_cell u_cell (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_en[i]),
        .wr_bit  (wr_val[i]),
        .dir_out (dir_q[i]),
        .gen_out (func_q[i]),
        .pin_in  (pin_in[i]),
        .pin_out (pin_out[i]),
        .pin_oe  (pin_oe[i]),
        .rd_bit  (rd_bits[i])
      );
    end
  endgenerate

  // Reserved high bits 15..8 and unused upper bits always read zero
  always @* begin
    rd_word = `PAD_WORD_ZERO;
    case (s_axi_araddr & `PAD_WORD_MASK)
      `PAD_OFF_LOW_DATA: begin
        rd_word[`PAD_LOW_BITS-1:0] = rd_bits[`PAD_LOW_BITS-1:0];
      end
      `PAD_OFF_HIGH_DATA: begin
        rd_word[PINS-`PAD_LOW_BITS-1:0] = rd_bits[PINS-1:`PAD_LOW_BITS];
      end
      `PAD_OFF_DIRECTION: begin
        rd_word[PINS-1:0] = dir_q;
      end
      `PAD_OFF_FUNCTION: begin
        rd_word[PINS-1:0] = func_q;
      end
      default: begin
        rd_word = `PAD_WORD_ZERO;
      end
    endcase
  end

  // Read channel holds one answer; arready stays low until it is taken
  always @* begin
    rvalid_d = s_axi_rvalid;
    rdata_d  = s_axi_rdata;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'h1;
      rdata_d  = rd_word;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'h0;
    end
  end

  // Pin levels are captured at the address edge; later pin moves are not seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata  <= `PAD_WORD_ZERO;
      s_axi_rresp  <= `PAD_RESP_OKAY;
    end else begin
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= `PAD_RESP_OKAY;
    end
  end
endmodule

// ===== logic/pad_map.vh
// Register map, field layout and reset values of the port A data block
`ifndef PAD_MAP_VH
`define PAD_MAP_VH
`define PAD_OFF_LOW_DATA   4'h0
`define PAD_OFF_HIGH_DATA  4'h4
`define PAD_OFF_DIRECTION  4'h8
`define PAD_OFF_FUNCTION   4'hC
`define PAD_PINS           24
`define PAD_LOW_BITS       16
`define PAD_HIGH_BITS      8
`define PAD_BIT_RESET      1'h0
`define PAD_WORD_MASK      4'hC
`define PAD_LANE_BITS      8
`define PAD_WORD_ZERO      32'h0000_0000
`define PAD_STRB_NONE      4'h0
`define PAD_DIR_RESET      24'h00_0000
`define PAD_FUNC_RESET     24'h00_0000
`define PAD_RESP_OKAY      2'h0
`define PAD_RESP_SLVERR    2'h2
`endif

// ===== logic/pad_pin_cell.v
// One port pin: stored bit, pin drive and read-back selection
`timescale 1ns/100ps
`include "pad_map.vh"
module pad_pin_cell (
  input  wire aclk,
  input  wire aresetn,
  input  wire wr_en,
  input  wire wr_bit,
  input  wire dir_out,
  input  wire gen_out,
  input  wire pin_in,
  output wire pin_out,
  output wire pin_oe,
  output wire rd_bit
);
  reg data_q;

  // Store on every write regardless of direction or function
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= `PAD_BIT_RESET;
    end else if (wr_en) begin
      data_q <= wr_bit;
    end
  end

  assign pin_out = data_q;
  // Drive only a general output whose direction bit is set
  assign pin_oe  = dir_out & gen_out;
  assign rd_bit  = dir_out ? data_q : pin_in;
endmodule

// ===== tb/pad_port_monitor.sv
// Bus and pin relation checker for the port A data block
`timescale 1ns/100ps
module pad_port_monitor #(
  parameter PINS = 24
) (
  input wire            aclk,
  input wire            aresetn,
  input wire [1:0]      s_axi_bresp,
  input wire            s_axi_bvalid,
  input wire            s_axi_bready,
  input wire [3:0]      s_axi_araddr,
  input wire            s_axi_arvalid,
  input wire            s_axi_arready,
  input wire [31:0]     s_axi_rdata,
  input wire            s_axi_rvalid,
  input wire            s_axi_rready,
  input wire [PINS-1:0] pin_out,
  input wire [PINS-1:0] pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_read_single: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_okay_resp: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("bad write response");
  a_low_width: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
    |=> s_axi_rdata[31:16] == 16'h0000) else $error("low register too wide");
  a_high_reserved: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h4
    |=> s_axi_rdata[31:8] == 24'h00_0000) else $error("reserved bits set");
  a_stored_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
    |=> ((s_axi_rdata[15:0] ^ $past(pin_out[15:0])) & $past(pin_oe[15:0])) == 16'h0000)
    else $error("driven pin read wrong");
  a_stored_high: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h4
    |=> ((s_axi_rdata[7:0] ^ $past(pin_out[23:16])) & $past(pin_oe[23:16])) == 8'h00)
    else $error("driven high pin read wrong");
  // Pin drive may only move on a write, never on a read
  a_pin_write: assert property (!$stable({pin_out, pin_oe})
    |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("pin moved without write");
endmodule
bind pad_port pad_port_monitor #(.PINS(PINS)) u_mon (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .pin_out       (pin_out),
  .pin_oe        (pin_oe)
);

// ===== tb/pad_pin_model.sv
// Outside world of the port pins: resolves each pin level
`timescale 1ns/100ps
module pad_pin_model (
  input  wire [23:0] pin_out,
  input  wire [23:0] pin_oe,
  input  wire [23:0] ext_level,
  output wire [23:0] pin_in
);
  // Undriven pins follow the outside level, never the last drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ===== tb/port_a_data_register_rw_test.sv
// Random and corner-case bench for the port A data block
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module port_a_data_register_rw_test;
  reg         aclk = 0;
  reg         aresetn = 0;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0;
  reg  [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  reg  [31:0] s_axi_wdata = '0, rd, want;
  reg  [23:0] ext_level = '0, dir, fn, v, e;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] pin_in, pin_out, pin_oe;
  integer     seed = 2, fail_count = 0, check_count = 0, i;
  pad_port DUT (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pin_in        (pin_in),
    .pin_out       (pin_out),
    .pin_oe        (pin_oe)
  );
  pad_pin_model u_pins (
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .ext_level (ext_level),
    .pin_in    (pin_in)
  );
  initial forever #4 aclk = ~aclk;
  function [23:0] mix(input [23:0] s, a, b);
    mix = (s & a) | (~s & b);
  endfunction
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Ready sampled at negedge so the reaction after posedge never races
  task xfer(input w, input [3:0] a, input [31:0] d);
    integer n;
    reg     ha, hw, hr, hb;
    begin
      s_axi_awaddr <= a; s_axi_araddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= w; s_axi_wvalid <= w; s_axi_bready <= w;
      s_axi_arvalid <= !w; s_axi_rready <= !w;
      n = 0; hb = 0;
      while (!hb && n < 20) begin
        @(negedge aclk);
        ha = s_axi_awready; hw = s_axi_wready; hr = s_axi_arready;
        hb = s_axi_bvalid | s_axi_rvalid; rd = s_axi_rdata;
        @(posedge aclk);
        if (ha) s_axi_awvalid <= 0;
        if (hw) s_axi_wvalid <= 0;
        if (hr) s_axi_arvalid <= 0;
        n = n + 1;
      end
      s_axi_bready <= 0; s_axi_rready <= 0;
      if (!hb) begin fail_count++; $display("[ERR] %0t transfer timed out", $time); disable run; end
      @(posedge aclk);
    end
  endtask
  initial begin
    begin : run
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      for (i = 0; i < 16; i = i + 4) begin xfer(0, i[3:0], '0); `CHK(rd, 32'h0000_0000) end
      `CHK(pin_oe | pin_out, 24'h00_0000)
      $display("reset test done");
      // First pass: all output, no general output; later passes random
      for (i = 0; i < 40; i = i + 1) begin
        dir = $random(seed) | {24{i == 0}}; fn = $random(seed) & {24{i != 0}};
        v = $random(seed);
        xfer(1, 4'h8, {8'h00, dir}); xfer(1, 4'hC, {8'h00, fn});
        xfer(1, 4'h0, {16'h0000, v[15:0]}); xfer(1, 4'h4, {24'h00_0000, v[23:16]});
        ext_level <= $random(seed);
        xfer(0, 4'h0, '0);
        e = mix(dir, v, ext_level);
        want = {16'h0000, e[15:0]};
        `CHK(rd, want)
        xfer(0, 4'h4, '0);
        want = {24'h00_0000, e[23:16]};
        `CHK(rd, want)
        `CHK(pin_oe, dir & fn)
        `CHK(pin_in, mix(dir & fn, v, ext_level))
      end
      $display("random test done");
      // Single-lane strobe keeps the other byte of the low register
      xfer(1, 4'h8, 32'h00FF_FFFF); xfer(1, 4'hC, 32'h00FF_FFFF);
      xfer(1, 4'h0, 32'h0000_FFFF);
      s_axi_wstrb <= 4'h1;
      xfer(1, 4'h0, 32'h0000_0000);
      s_axi_wstrb <= 4'hF;
      xfer(0, 4'h0, '0); `CHK(rd, 32'h0000_FF00)
      `CHK(pin_out[15:0], 16'hFF00)
      // Reset in mid-run must clear stored bits written before it
      aresetn <= 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      `CHK(pin_oe | pin_out, 24'h00_0000)
      xfer(1, 4'h8, 32'h00FF_FFFF);
      xfer(0, 4'h0, '0); `CHK(rd, 32'h0000_0000)
      xfer(0, 4'h4, '0); `CHK(rd, 32'h0000_0000)
      $display("strobe and reset test done");
    end
    give_verdict;
  end
endmodule
